// file: rtl/vector_feature_encoding_gate.sv
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module vector_feature_encoding_gate
  import vector_gate_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // decode verdict
  output logic decode_accept,
  output logic invalid_opcode,
  output logic cross_lane
);

  // ****************************************************************
  // opcode classification
  // ****************************************************************
  function automatic form_class_t class_of_0f(input logic [7:0] op);
    form_class_t c;
    case (op) inside
      8'h6e, 8'h7e, 8'hd6: begin
        c = cls_scalar;
      end
      8'hc4, 8'hc5: begin
        c = cls_word;
      end
      8'h6f, 8'h7f, 8'he7, 8'hf0: begin
        c = cls_move;
      end
      [8'h60:8'h6d], [8'h70:8'h76]: begin
        c = cls_int;
      end
      [8'hd1:8'hdf], [8'he0:8'hef], [8'hf1:8'hfe]: begin
        c = cls_int;
      end
      default: begin
        c = cls_none;
      end
    endcase
    return c;
  endfunction

  function automatic form_class_t class_of_0f38(input logic [7:0] op);
    form_class_t c;
    case (op) inside
      [8'h00:8'h0b], [8'h1c:8'h1e]: begin
        c = cls_int;
      end
      [8'h20:8'h25], [8'h30:8'h35]: begin
        c = cls_extend;
      end
      8'h16, 8'h36, [8'h58:8'h5a]: begin
        c = cls_cross_new;
      end
      [8'h45:8'h47]: begin
        c = cls_varshift;
      end
      [8'h90:8'h93]: begin
        c = cls_gather;
      end
      [8'h96:8'hbf]: begin
        c = cls_fma;
      end
      default: begin
        c = cls_none;
      end
    endcase
    return c;
  endfunction

  function automatic form_class_t class_of(input logic [1:0] map, input logic [7:0] op);
    form_class_t c;
    c = cls_none;
    if (map == map_0f) begin
      c = class_of_0f(op);
    end else if (map == map_0f38) begin
      c = class_of_0f38(op);
    end
    return c;
  endfunction

  // ****************************************************************
  // feature gating helpers
  // ****************************************************************
  function automatic logic os_state_ok(input logic [3:0] feat, input logic [7:0] xcr);
    logic ok;
    ok = feat[feat_os_save_pos];
    ok = ok && xcr[xcr_narrow_state_pos] && xcr[xcr_wide_state_pos];
    return ok;
  endfunction

  function automatic logic width_gate(input logic wide, input logic base, input logic gen2);
    logic ok;
    ok = wide ? gen2 : base;
    return ok;
  endfunction

  // ****************************************************************
  // gating verdict
  // ****************************************************************
  function automatic verdict_t judge(input logic [11:0] req, input logic [3:0] feat,
                                     input logic [7:0] xcr);
    verdict_t v;
    logic wide;
    logic base;
    logic gen2;
    logic os_ok;
    logic ok;
    wide = req[req_wide_pos];
    base = feat[feat_base_pos];
    gen2 = feat[feat_gen2_pos];
    os_ok = os_state_ok(feat, xcr);
    v.cls = class_of(req[req_map_pos +: 2], req[7:0]);
    v.cross_lane = 1'b0;
    v.in_lane = 1'b0;
    v.elem64 = 1'b0;
    case (v.cls)
      cls_scalar, cls_word: begin
        ok = base && !wide;
      end
      cls_move: begin
        ok = base;
      end
      cls_int: begin
        ok = width_gate(wide, base, gen2);
        v.in_lane = wide;
      end
      cls_extend: begin
        ok = width_gate(wide, base, gen2);
        v.cross_lane = wide;
      end
      cls_cross_new: begin
        ok = gen2;
        v.cross_lane = wide;
      end
      cls_gather, cls_varshift: begin
        ok = gen2;
        v.elem64 = req[req_w_pos];
        v.in_lane = wide && (v.cls == cls_varshift);
      end
      cls_fma: begin
        ok = base && feat[feat_fma_pos];
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    v.accept = ok && os_ok;
    v.fault = !v.accept;
    return v;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  gate_regs_t r;
  gate_regs_t next_r;
  logic addr_phase;
  logic [31:0] id_ecx;
  logic [31:0] result_word;

  // ****************************************************************
  // identification result
  // ****************************************************************
  always_comb begin
    id_ecx = 32'h0000_0000;
    id_ecx[id_fma_pos] = r.features[feat_fma_pos];
    id_ecx[id_os_save_pos] = r.features[feat_os_save_pos];
    id_ecx[id_base_pos] = r.features[feat_base_pos];
  end

  // ****************************************************************
  // result word
  // ****************************************************************
  always_comb begin
    result_word = 32'h0000_0000;
    result_word[res_accept_pos] = r.verdict.accept;
    result_word[res_fault_pos] = r.verdict.fault;
    result_word[res_cross_pos] = r.verdict.cross_lane;
    result_word[res_in_lane_pos] = r.verdict.in_lane;
    result_word[res_elem64_pos] = r.verdict.elem64;
    result_word[res_class_pos +: 4] = r.verdict.cls;
    result_word[res_busy_pos] = (r.fsm != st_idle);
  end

  // ****************************************************************
  // bus address phase
  // ****************************************************************
  assign addr_phase = hsel && htrans[1] && hready;

  always_comb begin
    next_r = r;
    next_r.wr_pend = 1'b0;
    // ****************************************************************
    // bus address phase and read data
    // ****************************************************************
    if (addr_phase) begin
      next_r.wr_pend = hwrite;
      next_r.wr_addr = haddr[7:0];
      next_r.hrdata = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr[7:0])
          feature_ctrl_offset: begin
            next_r.hrdata = {28'h0000000, r.features};
          end
          extended_control_register_zero_offset: begin
            next_r.hrdata = {24'h000000, r.xcr};
          end
          id_ecx_offset: begin
            next_r.hrdata = id_ecx;
          end
          request_offset: begin
            next_r.hrdata = {20'h00000, r.request};
          end
          result_offset: begin
            next_r.hrdata = result_word;
          end
          fault_count_offset: begin
            next_r.hrdata = {16'h0000, r.fault_count};
          end
          default: begin
            next_r.hrdata = 32'h0000_0000;
          end
        endcase
      end
    end
    // ****************************************************************
    // decode sequence
    // ****************************************************************
    case (r.fsm)
      st_idle: begin
        next_r.fsm = st_idle;
      end
      st_eval: begin
        next_r.verdict = judge(r.request, r.features, r.xcr);
        next_r.fsm = st_report;
      end
      st_report: begin
        if (r.verdict.fault) begin
          next_r.fault_count = r.fault_count + 16'h0001;
        end
        next_r.fsm = st_idle;
      end
      default: begin
        next_r.fsm = st_idle;
      end
    endcase
    // ****************************************************************
    // bus data phase writes
    // ****************************************************************
    if (r.wr_pend) begin
      case (r.wr_addr)
        feature_ctrl_offset: begin
          next_r.features = hwdata[3:0];
        end
        extended_control_register_zero_offset: begin
          next_r.xcr = hwdata[7:0];
        end
        request_offset: begin
          if (r.fsm == st_idle) begin
            next_r.request = hwdata[11:0];
            next_r.fsm = st_eval;
          end
        end
        fault_count_offset: begin
          if (r.fsm == st_report && r.verdict.fault) begin
            next_r.fault_count = 16'h0001;
          end else begin
            next_r.fault_count = 16'h0000;
          end
        end
        default: begin
          next_r.wr_addr = r.wr_addr;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r.fsm <= st_idle;
      r.wr_pend <= 1'b0;
      r.wr_addr <= 8'h00;
      r.features <= feature_reset;
      r.xcr <= xcr_reset;
      r.request <= request_reset;
      r.verdict <= '0;
      r.fault_count <= 16'h0000;
      r.hrdata <= 32'h0000_0000;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic hreadyout_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign decode_accept = r.verdict.accept;
  assign invalid_opcode = r.verdict.fault;
  assign cross_lane = r.verdict.cross_lane;

endmodule
`default_nettype wire

// file: rtl/vector_gate_pkg.sv
`default_nettype none
package vector_gate_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] feature_ctrl_offset = 8'h00;
  localparam logic [7:0] extended_control_register_zero_offset = 8'h04;
  localparam logic [7:0] id_ecx_offset = 8'h08;
  localparam logic [7:0] request_offset = 8'h0c;
  localparam logic [7:0] result_offset = 8'h10;
  localparam logic [7:0] fault_count_offset = 8'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int feat_base_pos = 0;
  localparam int feat_gen2_pos = 1;
  localparam int feat_fma_pos = 2;
  localparam int feat_os_save_pos = 3;
  localparam int id_fma_pos = 12;
  localparam int id_os_save_pos = 27;
  localparam int id_base_pos = 28;
  localparam int xcr_narrow_state_pos = 1;
  localparam int xcr_wide_state_pos = 2;
  localparam int req_map_pos = 8;
  localparam int req_wide_pos = 10;
  localparam int req_w_pos = 11;
  localparam int res_accept_pos = 0;
  localparam int res_fault_pos = 1;
  localparam int res_cross_pos = 2;
  localparam int res_in_lane_pos = 3;
  localparam int res_elem64_pos = 4;
  localparam int res_class_pos = 8;
  localparam int res_busy_pos = 31;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [3:0] feature_reset = 4'hf;
  localparam logic [7:0] xcr_reset = 8'h07;
  localparam logic [11:0] request_reset = 12'h000;

  // ****************************************************************
  // opcode maps and classes
  // ****************************************************************
  localparam logic [1:0] map_0f = 2'h0;
  localparam logic [1:0] map_0f38 = 2'h1;
  localparam logic [1:0] map_0f3a = 2'h2;

  typedef enum logic [3:0] {
    cls_none = 4'h0,
    cls_scalar = 4'h1,
    cls_word = 4'h2,
    cls_move = 4'h3,
    cls_int = 4'h4,
    cls_extend = 4'h5,
    cls_gather = 4'h6,
    cls_varshift = 4'h7,
    cls_cross_new = 4'h8,
    cls_fma = 4'h9
  } form_class_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_eval = 2'b01,
    st_report = 2'b11
  } gate_state_t;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic accept;
    logic fault;
    logic cross_lane;
    logic in_lane;
    logic elem64;
    form_class_t cls;
  } verdict_t;

  typedef struct packed {
    gate_state_t fsm;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [3:0] features;
    logic [7:0] xcr;
    logic [11:0] request;
    verdict_t verdict;
    logic [15:0] fault_count;
    logic [31:0] hrdata;
  } gate_regs_t;

endpackage
`default_nettype wire

// file: tb/vector_feature_encoding_gate_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module vector_feature_encoding_gate_tb_top
  import vector_gate_pkg::*;
;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [2:0] hsize;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic decode_accept;
  wire logic invalid_opcode;
  wire logic cross_lane;
  wire logic hresp;
  logic [31:0] q;
  logic [31:0] v;
  logic [9:0] dir [10];
  int err_total;
  int checked;
  int faults;
  int cyc;
  int seed = 47294;
  vector_feature_encoding_gate dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .decode_accept(decode_accept), .invalid_opcode(invalid_opcode), .cross_lane(cross_lane));
  // ****************************************************************
  // model and bus tasks
  // ****************************************************************
  function automatic logic [11:0] model(logic [3:0] f, logic [7:0] x, logic [11:0] r);
    logic [3:0] c;
    logic ok;
    c = 4'h0;
    if (r[9:8] == 2'h0) begin
      if (r[7:0] inside {8'h6e, 8'h7e, 8'hd6}) c = 4'h1;
      else if (r[7:0] inside {8'hc4, 8'hc5}) c = 4'h2;
      else if (r[7:0] inside {8'h6f, 8'h7f, 8'he7, 8'hf0}) c = 4'h3;
      else if (r[7:0] inside {[8'h60:8'h6d], [8'h70:8'h76], [8'hd1:8'hef], [8'hf1:8'hfe]}) c = 4'h4;
    end else if (r[9:8] == 2'h1) begin
      if (r[7:0] inside {[8'h00:8'h0b], [8'h1c:8'h1e]}) c = 4'h4;
      else if (r[7:0] inside {[8'h20:8'h25], [8'h30:8'h35]}) c = 4'h5;
      else if (r[7:0] inside {[8'h90:8'h93]}) c = 4'h6;
      else if (r[7:0] inside {[8'h45:8'h47]}) c = 4'h7;
      else if (r[7:0] inside {8'h16, 8'h36, [8'h58:8'h5a]}) c = 4'h8;
      else if (r[7:0] inside {[8'h96:8'hbf]}) c = 4'h9;
    end
    case (c)
      4'h1, 4'h2: ok = !r[10] && f[0];
      4'h3: ok = f[0];
      4'h4, 4'h5: ok = r[10] ? f[1] : f[0];
      4'h6, 4'h7, 4'h8: ok = f[1];
      4'h9: ok = f[0] && f[2];
      default: ok = 1'b0;
    endcase
    ok = ok && f[3] && x[1] && x[2];
    return {c, 3'h0, r[11] && (c == 4'h6 || c == 4'h7), r[10] && (c == 4'h4 || c == 4'h7),
            r[10] && (c == 4'h5 || c == 4'h8), !ok, ok};
  endfunction
  task chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk("reg", e, r);
  endtask
  task run(logic [3:0] f, logic [7:0] x, logic [11:0] r);
    logic [31:0] s;
    logic [11:0] e;
    int n;
    xfer(1'b1, feature_ctrl_offset, {28'h0, f}, s);
    xfer(1'b1, extended_control_register_zero_offset, {24'h0, x}, s);
    xfer(1'b1, request_offset, {20'h0, r}, s);
    s = 32'h8000_0000;
    n = 0;
    while (s[31] && n < 20) begin
      xfer(1'b0, result_offset, 32'h0, s);
      n++;
    end
    e = model(f, x, r);
    faults += int'(e[1]);
    chk("result", {20'h0, e}, s);
    chk("pins", {29'h0, e[2:0]}, {29'h0, cross_lane, invalid_opcode, decode_accept});
    rd(id_ecx_offset, {3'h0, f[0], f[3], 14'h0, f[2], 12'h0});
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****************************************************************
  // clock, timeout, sequence
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    dir = '{10'h06e, 10'h0c4, 10'h06f, 10'h0d4, 10'h120, 10'h190, 10'h145, 10'h116, 10'h1a8, 10'h2aa};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(feature_ctrl_offset, {28'h0, feature_reset});
    rd(extended_control_register_zero_offset, {24'h0, xcr_reset});
    xfer(1'b1, id_ecx_offset, 32'h0, q);
    rd(id_ecx_offset, 32'h1800_1000);
    xfer(1'b0, id_ecx_offset, 32'h0, q);
    chk("base flag", 32'h1, {31'h0, q[id_base_pos]});
    chk("fma flag", 32'h1, {31'h0, q[id_fma_pos]});
    xfer(1'b1, 8'h20, 32'hffff_ffff, q);
    rd(8'h20, 32'h0);
    for (int i = 0; i < 10; i++) begin
      for (int j = 0; j < 4; j++) begin
        run(j[1] ? 4'hf : 4'hd, 8'h07, {j[1], j[0], dir[i]});
      end
    end
    run(4'h7, 8'h07, 12'h46f);
    run(4'hf, 8'h03, 12'h46f);
    for (int i = 0; i < 40; i++) begin
      v = $random(seed);
      run(v[0] ? 4'hf : v[7:4], v[1] ? 8'h07 : v[15:8], v[27:16]);
    end
    rd(fault_count_offset, {16'h0, faults[15:0]});
    xfer(1'b1, fault_count_offset, 32'h0, q);
    rd(fault_count_offset, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire

// file: tb/vector_gate_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module vector_gate_asserts
  import vector_gate_pkg::*;
(
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // verdict
  input wire logic decode_accept,
  input wire logic invalid_opcode,
  input wire logic cross_lane
);
  // ****************************************************************
  // bus shadow
  // ****************************************************************
  logic rd_dp;
  logic wr_dp;
  logic [7:0] dp_a;
  logic [3:0] feat;
  logic [7:0] xcr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp <= 1'b0;
      wr_dp <= 1'b0;
      dp_a <= 8'h00;
      feat <= feature_reset;
      xcr <= xcr_reset;
    end else begin
      rd_dp <= hsel && htrans[1] && hready && !hwrite;
      wr_dp <= hsel && htrans[1] && hready && hwrite;
      dp_a <= haddr[7:0];
      if (wr_dp && dp_a == feature_ctrl_offset) begin
        feat <= hwdata[3:0];
      end
      if (wr_dp && dp_a == extended_control_register_zero_offset) begin
        xcr <= hwdata[7:0];
      end
    end
  end
  wire logic req = wr_dp && dp_a == request_offset;
  wire logic os_ok = feat[3] && xcr[1] && xcr[2];
  wire logic [7:0] op = hwdata[7:0];
  wire logic m0 = hwdata[9:8] == map_0f;
  wire logic m1 = hwdata[9:8] == map_0f38;
  wire logic wide = hwdata[10];
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take;
    req && os_ok;
  endsequence
  sequence s_fault;
    ##3 invalid_opcode && !decode_accept;
  endsequence
  a_id_flags: assert property (rd_dp && dp_a == id_ecx_offset |->
    hrdata[12] == feat[2] && hrdata[28] == feat[0] && hrdata[27] == feat[3])
    else $error("id flags wrong");
  a_no_os_state: assert property (req && !os_ok |-> s_fault)
    else $error("no fault without os state");
  a_wide_int: assert property (s_take ##0 (m0 && wide && op inside {[8'h60:8'h6d]})
    |-> ##3 decode_accept == feat[1] && !cross_lane) else $error("wide int gate wrong");
  a_narrow_int: assert property (s_take ##0 (m0 && !wide && op inside {[8'h60:8'h6d]})
    |-> ##3 decode_accept == feat[0]) else $error("narrow int gate wrong");
  a_no_wide_scalar: assert property (s_take ##0 (m0 && wide &&
    op inside {8'h6e, 8'h7e, 8'hd6, 8'hc4, 8'hc5}) |-> s_fault) else $error("wide scalar taken");
  a_wide_move: assert property (s_take ##0 (m0 && wide &&
    op inside {8'h6f, 8'h7f, 8'he7, 8'hf0}) |-> ##3 decode_accept == feat[0])
    else $error("wide move gate wrong");
  a_cross_extend: assert property (s_take ##0 (m1 && wide && feat[1] &&
    op inside {[8'h20:8'h25], [8'h30:8'h35]}) |-> ##3 decode_accept && cross_lane)
    else $error("extend not cross lane");
  a_fma_forms: assert property (s_take ##0 (m1 && feat[0] && feat[2] &&
    op inside {[8'h96:8'hbf]}) |-> ##3 decode_accept) else $error("fma form refused");
  a_verdict_hold: assert property (decode_accept != $past(decode_accept) |->
    $past(req, 2)) else $error("verdict moved without request");
endmodule
bind vector_feature_encoding_gate vector_gate_asserts chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .decode_accept(decode_accept), .invalid_opcode(invalid_opcode), .cross_lane(cross_lane));
`default_nettype wire
